/* cm_pkg.sv */
`default_nettype none
package cm_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0]  CM_OFS_CTRL_A  = 4'h0;
	localparam logic [3:0]  CM_OFS_CTRL_B  = 4'h4;
	localparam logic [3:0]  CM_OFS_STATUS  = 4'h8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          CM_A_PATH      = 0;
	localparam int          CM_A_PRESC_LSB = 4;
	localparam int          CM_A_CP_LSB    = 8;
	localparam int          CM_A_M_LSB     = 16;
	localparam int          CM_B_SLEEP     = 0;
	localparam int          CM_B_TUNE_LSB  = 8;
	localparam int          CM_B_N_LSB     = 16;
	localparam int          CM_B_DUAL      = 24;
	localparam int          CM_S_ACTIVE    = 0;
	localparam int          CM_S_RATIO_OK  = 1;
	localparam int          CM_S_EXT_FILT  = 2;
	localparam int          CM_S_RATIO_LSB = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] CM_RST_CTRL_A  = 32'h0004_0170;
	localparam logic [31:0] CM_RST_CTRL_B  = 32'h0001_0001;

	// ------------------------------------------------------------
	// Prescaler codes, charge pump code and loop limits
	// ------------------------------------------------------------
	localparam logic [2:0]  CM_PRESC_DIV8  = 3'h7;
	localparam logic [2:0]  CM_PRESC_DIV6  = 3'h6;
	localparam logic [2:0]  CM_PRESC_DIV5  = 3'h5;
	localparam logic [2:0]  CM_PRESC_DIV4  = 3'h4;
	localparam logic [1:0]  CM_CP_SINGLE   = 2'h1;
	localparam logic [10:0] CM_RATIO_MIN   = 11'h018;
	localparam logic [10:0] CM_RATIO_MAX   = 11'h1E0;
	localparam logic [10:0] CM_RATIO_INT   = 11'h078;

endpackage : cm_pkg
`default_nettype wire

/* cm_div.sv */
`timescale 1ns/100ps
`default_nettype none
module cm_div
	import cm_pkg::*;
(
	input  wire logic       clk,   // System clock.
	input  wire logic       rstn,  // Synchronous reset, active low.
	input  wire logic       clr,   // Holds the divider at count zero.
	input  wire logic       tick,  // Input event to be divided.
	input  wire logic [7:0] div,   // Divide value, zero acts as one.
	output logic            pulse  // One pulse per div input events.
);
	logic [7:0] cnt;
	wire  [7:0] last = (div == 8'h00) ? 8'h00 : div - 8'h01;
	wire        wrap = tick && (cnt >= last);

	always_ff @(posedge clk) begin
		if (!rstn || clr) begin
			cnt   <= 8'h00;
			pulse <= 1'b0;
		end else begin
			cnt   <= wrap ? 8'h00 : (tick ? cnt + 8'h01 : cnt);
			pulse <= wrap;
		end
	end
endmodule : cm_div
`default_nettype wire

/* cm_avs.sv */
`timescale 1ns/100ps
`default_nettype none
module cm_avs
	import cm_pkg::*;
(
	input  wire logic        clk,         // System clock.
	input  wire logic        rstn,        // Synchronous reset, active low.
	input  wire logic        read,        // Avalon read request.
	input  wire logic        write,       // Avalon write request.
	input  wire logic [31:0] rd_value,    // Word selected by the address.
	output logic             waitrequest, // Avalon waitrequest.
	output logic [31:0]      readdata,    // Avalon read data.
	output logic             wr_take      // Write takes effect this edge.
);
	// ------------------------------------------------------------
	// One wait state: every request is answered on the next edge.
	// ------------------------------------------------------------
	wire req = read || write;

	assign wr_take = write && !waitrequest;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			waitrequest <= !(req && waitrequest);
			if (read && waitrequest)
				readdata <= rd_value;
		end
	end

	a_bus_answer : assert property (@(posedge clk) disable iff (!rstn)
		(req && waitrequest) |=> !waitrequest ##1 waitrequest)
		else $error("bus request not answered in one wait state");
endmodule : cm_avs
`default_nettype wire

/* cm_clock_mult.sv */
// Operation
// - In multiplier mode the input clock is the loop reference.
// - Path-select one takes the sample clock from the multiplier.
// - Sleep zero powers the loop; multiplier mode needs it and path-select.
// - Prescaler codes 111, 110, 101, 100 divide by 8, 6, 5, 4.
// - A six-bit coarse tune field shifts the VCO centre.
// - An eight-bit binary M value divides the phase detector rate.
// - The N divider lowers the phase detector rate below the reference.
// - Charge pump code 01 selects the single current option.
// - In multiplier mode the sync strobe is generated internally.
// - The internal sync strobe comes from the N divider output.
// - Dual sync resets write pointer by input sync, read by strobe.
// - Path-select zero bypasses the loop; sleep one stops loop and VCO.
`timescale 1ns/100ps
`default_nettype none
module cm_clock_mult
	import cm_pkg::*;
(
	input  wire logic        clk,                // System clock, 250 MHz.
	input  wire logic        rstn,               // Synchronous reset, active low.
	input  wire logic [3:0]  avs_address,        // Avalon byte address.
	input  wire logic        avs_read,           // Avalon read.
	input  wire logic        avs_write,          // Avalon write.
	input  wire logic [31:0] avs_writedata,      // Avalon write data.
	input  wire logic [3:0]  avs_byteenable,     // Avalon byte enables.
	output logic [31:0]      avs_readdata,       // Avalon read data.
	output logic             avs_waitrequest,    // Avalon waitrequest.
	input  wire logic        sample_clock_input, // Reference edge, one-cycle enable.
	input  wire logic        ext_strobe_in,      // External sync strobe edge.
	input  wire logic        input_sync,         // Input-side FIFO sync edge.
	output logic             dac_clk_en,         // Sample clock enable.
	output logic             vco_enable,         // Loop and VCO powered.
	output logic [5:0]       vco_coarse_tune,    // VCO centre tuning.
	output logic [1:0]       charge_pump_select, // Charge pump current option.
	output logic             pfd_up,             // Reference leads feedback.
	output logic             pfd_dn,             // Feedback leads reference.
	output logic             output_sync_strobe, // Sync strobe to the FIFO side.
	output logic             fifo_write_reset,   // FIFO write pointer reset.
	output logic             fifo_read_reset     // FIFO read pointer reset.
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0] multiplier_control_word_a;
	logic [31:0] multiplier_control_word_b;
	logic [31:0] status_word;
	logic [31:0] rd_value;
	logic        wr_take;
	logic [31:0] be_mask;

	cm_avs u_avs (
		.clk         (clk),
		.rstn        (rstn),
		.read        (avs_read),
		.write       (avs_write),
		.rd_value    (rd_value),
		.waitrequest (avs_waitrequest),
		.readdata    (avs_readdata),
		.wr_take     (wr_take)
	);

	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	wire wr_a = wr_take && (avs_address == CM_OFS_CTRL_A);
	wire wr_b = wr_take && (avs_address == CM_OFS_CTRL_B);

	wire [31:0] next_word_a = (multiplier_control_word_a & ~be_mask)
	                        | (avs_writedata & be_mask);
	wire [31:0] next_word_b = (multiplier_control_word_b & ~be_mask)
	                        | (avs_writedata & be_mask);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			multiplier_control_word_a <= CM_RST_CTRL_A;
			multiplier_control_word_b <= CM_RST_CTRL_B;
		end else begin
			if (wr_a)
				multiplier_control_word_a <= next_word_a;
			if (wr_b)
				multiplier_control_word_b <= next_word_b;
		end
	end

	// Unmapped addresses read as zero and ignore writes.
	assign rd_value = (avs_address == CM_OFS_CTRL_A) ? multiplier_control_word_a :
	                  (avs_address == CM_OFS_CTRL_B) ? multiplier_control_word_b :
	                  (avs_address == CM_OFS_STATUS) ? status_word : 32'h0000_0000;

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	wire       path_select = multiplier_control_word_a[CM_A_PATH];
	wire [2:0] presc_code  = multiplier_control_word_a[CM_A_PRESC_LSB +: 3];
	wire [1:0] cp_field    = multiplier_control_word_a[CM_A_CP_LSB +: 2];
	wire [7:0] m_value     = multiplier_control_word_a[CM_A_M_LSB +: 8];
	wire       sleep       = multiplier_control_word_b[CM_B_SLEEP];
	wire [5:0] tune_field  = multiplier_control_word_b[CM_B_TUNE_LSB +: 6];
	wire [7:0] n_value     = multiplier_control_word_b[CM_B_N_LSB +: 8];
	wire       dual_sync   = multiplier_control_word_b[CM_B_DUAL];

	// Codes below 100 are not defined; they fall back to the smallest divide.
	wire [7:0] presc_div = (presc_code == CM_PRESC_DIV8) ? 8'h08 :
	                       (presc_code == CM_PRESC_DIV6) ? 8'h06 :
	                       (presc_code == CM_PRESC_DIV5) ? 8'h05 :
	                                                       8'h04;

	wire multiplier_mode = path_select && !sleep;

	// Loop ratio is reported so software can check its own limits.
	wire [10:0] loop_ratio = 11'(presc_div[3:0] * m_value);
	wire ratio_ok = (loop_ratio >= CM_RATIO_MIN) && (loop_ratio <= CM_RATIO_MAX);
	wire ext_filter = loop_ratio > CM_RATIO_INT;

	assign status_word = {5'h00, loop_ratio, 13'h0000, ext_filter, ratio_ok,
	                      multiplier_mode};

	// ------------------------------------------------------------
	// Loop model: the VCO runs at the system rate while powered
	// ------------------------------------------------------------
	logic mult_tick;
	logic fb_pulse;
	logic ref_pulse;

	// The prescaler is cleared while asleep so the first output edge after
	// wake-up comes a full divide period later, never a short one.
	cm_div u_presc (
		.clk   (clk),
		.rstn  (rstn),
		.clr   (!vco_enable),
		.tick  (vco_enable),
		.div   (presc_div),
		.pulse (mult_tick)
	);

	cm_div u_mdiv (
		.clk   (clk),
		.rstn  (rstn),
		.clr   (!vco_enable),
		.tick  (mult_tick),
		.div   (m_value),
		.pulse (fb_pulse)
	);

	cm_div u_ndiv (
		.clk   (clk),
		.rstn  (rstn),
		.clr   (1'b0),
		.tick  (sample_clock_input),
		.div   (n_value),
		.pulse (ref_pulse)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			vco_enable         <= 1'b0;
			vco_coarse_tune    <= 6'h00;
			charge_pump_select <= 2'h0;
			dac_clk_en         <= 1'b0;
			pfd_up             <= 1'b0;
			pfd_dn             <= 1'b0;
			output_sync_strobe <= 1'b0;
			fifo_write_reset   <= 1'b0;
			fifo_read_reset    <= 1'b0;
		end else begin
			vco_enable         <= !sleep;
			vco_coarse_tune    <= tune_field;
			charge_pump_select <= cp_field;
			dac_clk_en         <= path_select ? mult_tick
			                                  : sample_clock_input;
			pfd_up             <= multiplier_mode && ref_pulse && !fb_pulse;
			pfd_dn             <= multiplier_mode && fb_pulse && !ref_pulse;
			output_sync_strobe <= multiplier_mode ? ref_pulse
			                                      : ext_strobe_in;
			fifo_write_reset   <= input_sync;
			fifo_read_reset    <= dual_sync ? output_sync_strobe
			                                : input_sync;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_quiet7;
		!mult_tick [*7];
	endsequence

	a_mult_path : assert property (
		(path_select && mult_tick) |=> dac_clk_en)
		else $error("multiplier tick not passed to sample clock");

	a_bypass_path : assert property (
		(!path_select && sample_clock_input) |=> dac_clk_en)
		else $error("input clock not passed in bypass");

	a_no_leak : assert property (
		(path_select && !mult_tick) |=> !dac_clk_en)
		else $error("input clock leaked into multiplier path");

	a_sleep_vco : assert property (
		(sleep && !wr_b) [*3] |-> !vco_enable && !mult_tick)
		else $error("VCO running while asleep");

	a_presc_eight : assert property (disable iff (!rstn || wr_a || sleep)
		(mult_tick && presc_code == CM_PRESC_DIV8) |=> s_quiet7 ##1 mult_tick)
		else $error("prescaler code 111 not dividing by 8");

	a_strobe_int : assert property (
		(multiplier_mode && ref_pulse) |=> output_sync_strobe)
		else $error("N divider output not on sync strobe");

	a_strobe_ext : assert property (
		(multiplier_mode && !ref_pulse && ext_strobe_in) |=> !output_sync_strobe)
		else $error("external strobe used in multiplier mode");

	a_rd_reset : assert property (
		(dual_sync && ref_pulse && multiplier_mode && !wr_b)
		|=> ##1 fifo_read_reset)
		else $error("read pointer not reset by sync strobe");

	a_wr_reset : assert property (
		input_sync |=> fifo_write_reset)
		else $error("write pointer not reset by input sync");

	a_pfd_excl : assert property (
		!(pfd_up && pfd_dn))
		else $error("both phase detector outputs active");

	// ------------------------------------------------------------
	// Divider, copy and pass-through checks
	// ------------------------------------------------------------
	sequence s_quiet3;
		!mult_tick [*3];
	endsequence

	a_presc_four : assert property (disable iff (!rstn || wr_a || sleep)
		(mult_tick && presc_code == CM_PRESC_DIV4) |=> s_quiet3 ##1 mult_tick)
		else $error("prescaler code 100 not dividing by 4");

	a_fb_source : assert property (
		fb_pulse |-> $past(mult_tick))
		else $error("M divider pulse without prescaler tick");

	a_ref_source : assert property (
		ref_pulse |-> $past(sample_clock_input))
		else $error("N divider pulse without reference edge");

	a_up_source : assert property (
		pfd_up |-> $past(multiplier_mode && ref_pulse))
		else $error("phase detector up without reference pulse");

	a_dn_source : assert property (
		pfd_dn |-> $past(multiplier_mode && fb_pulse))
		else $error("phase detector down without feedback pulse");

	a_cp_single : assert property (
		(cp_field == CM_CP_SINGLE) |=> (charge_pump_select == CM_CP_SINGLE))
		else $error("single charge pump option not selected");

	a_tune_copy : assert property (
		1'b1 |=> (vco_coarse_tune == $past(tune_field)))
		else $error("coarse tune not passed to the VCO");

	a_wake_vco : assert property (
		!sleep |=> vco_enable)
		else $error("VCO not powered while awake");

	a_rest_vco : assert property (
		sleep |=> !vco_enable)
		else $error("VCO powered while asleep");

	a_bypass_idle : assert property (
		(!path_select && !sample_clock_input) |=> !dac_clk_en)
		else $error("sample clock without input edge in bypass");

	a_rd_single : assert property (
		(!dual_sync && input_sync) |=> fifo_read_reset)
		else $error("read pointer not reset by input sync");

	a_wr_quiet : assert property (
		!input_sync |=> !fifo_write_reset)
		else $error("write pointer reset without input sync");

	a_strobe_pass : assert property (
		(!multiplier_mode && ext_strobe_in) |=> output_sync_strobe)
		else $error("external strobe not passed outside multiplier mode");

	// The prescaler may still fire once while the VCO enable drains after sleep.
	a_mult_asleep : assert property (
		(path_select && sleep) [*4] |-> !dac_clk_en)
		else $error("sample clock running in multiplier path while asleep");

endmodule : cm_clock_mult
`default_nettype wire

/* cm_ref_src.sv */
`timescale 1ns/100ps
`default_nettype none
module cm_ref_src
	import cm_pkg::*;
(
	input  wire logic       clk,    // System clock.
	input  wire logic       rstn,   // Synchronous reset, active low.
	input  wire logic       start,  // Starts a burst of reference edges.
	input  wire logic [7:0] edges,  // Edges in the burst.
	input  wire logic [3:0] gap,    // Cycles from one edge to the next.
	output logic            ref_en, // Reference edge enable.
	output logic            busy    // Burst in progress.
);
	logic [7:0] left;
	logic [3:0] cnt;

	assign busy = (left != 8'h00);

	// Between bursts the reference stands still, so no stray edge reaches the loop.
	always_ff @(posedge clk) begin
		if (!rstn || start) begin
			left   <= start ? edges : 8'h00;
			cnt    <= 4'h0;
			ref_en <= 1'b0;
		end else if (busy && cnt == 4'h0) begin
			ref_en <= 1'b1;
			left   <= left - 8'h01;
			cnt    <= gap - 4'h1;
		end else begin
			ref_en <= 1'b0;
			cnt    <= (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
		end
	end
endmodule : cm_ref_src
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import cm_pkg::*;
;
	logic        clk = 0, rstn = 0, avs_read = 0, avs_write = 0, start = 0;
	logic        ext_strobe_in = 0, input_sync = 0, mode_byp = 1, prev_ref = 0, prev_is = 0;
	logic [3:0]  avs_address = 0, avs_byteenable = 0, gap = 4'h1;
	logic [31:0] avs_writedata = 0, avs_readdata, e;
	logic [7:0]  edges = 0;
	logic [15:0] lfsr = 16'h85DF;
	logic [5:0]  vco_coarse_tune, t;
	logic [1:0]  charge_pump_select;
	logic        avs_waitrequest, ref_en, busy, dac_clk_en, vco_enable, pfd_up, pfd_dn;
	logic        output_sync_strobe, fifo_write_reset, fifo_read_reset;
	logic [31:0] exp_q[$];
	int          num_errors = 0, tests_run = 0, cyc = 0, n_dac, n_str, n_rr, n_wr, n_cy, r;
	int          n_up, n_dn;
	logic [2:0]  pc[5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h7};
	logic [7:0]  mv[5] = '{8'h03, 8'h50, 8'h18, 8'h05, 8'h3D};
	int          dv[5] = '{8, 6, 5, 4, 8};

	always #2 clk = ~clk;

	cm_ref_src src (.clk(clk), .rstn(rstn), .start(start), .edges(edges), .gap(gap),
		.ref_en(ref_en), .busy(busy));
	cm_clock_mult dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sample_clock_input(ref_en), .ext_strobe_in(ext_strobe_in), .input_sync(input_sync),
		.dac_clk_en(dac_clk_en), .vco_enable(vco_enable), .vco_coarse_tune(vco_coarse_tune),
		.charge_pump_select(charge_pump_select), .pfd_up(pfd_up), .pfd_dn(pfd_dn),
		.output_sync_strobe(output_sync_strobe), .fifo_write_reset(fifo_write_reset),
		.fifo_read_reset(fifo_read_reset));

	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nx

	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (!ok) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk

	task automatic wrap_up;
		$display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	// ------------------------------------------------------------
	// Bus master: request held until waitrequest is seen low
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk);
		avs_read       <= !w;
		avs_write      <= w;
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		bus(1'b0, a, 32'h0, 4'h0);
	endtask : rd

	task automatic burst(input logic [7:0] n, input logic [3:0] g, input logic rnd);
		n_dac = 0;
		n_str = 0;
		n_rr  = 0;
		n_wr  = 0;
		n_cy  = 0;
		n_up  = 0;
		n_dn  = 0;
		@(posedge clk);
		start <= 1'b1;
		edges <= n;
		gap   <= g;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		while (busy) begin
			lfsr = nx(lfsr);
			ext_strobe_in <= rnd & lfsr[0];
			input_sync    <= lfsr[1] & !input_sync;
			@(posedge clk);
		end
		ext_strobe_in <= 1'b0;
		input_sync    <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask : burst

	// ------------------------------------------------------------
	// Output watcher
	// ------------------------------------------------------------
	always @(negedge clk) begin
		cyc++;
		n_cy++;
		n_dac += dac_clk_en;
		n_str += output_sync_strobe;
		n_rr  += fifo_read_reset;
		n_wr  += input_sync;
		n_up  += pfd_up;
		n_dn  += pfd_dn;
		if (mode_byp) chk(dac_clk_en === prev_ref, "bypass clock");
		chk(fifo_write_reset === prev_is, "write reset");
		prev_ref = ref_en;
		prev_is  = input_sync;
		if (avs_read && avs_waitrequest === 1'b0) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
			chk(avs_readdata === e, "read data");
		end
		if (cyc == 20000) begin
			chk(1'b0, "timeout");
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(avs_waitrequest === 1'b1 && charge_pump_select === 2'h0, "reset outputs");
		@(negedge clk);
		chk(vco_enable === 1'b0 && charge_pump_select === CM_CP_SINGLE, "reset");
		rd(CM_OFS_CTRL_A, CM_RST_CTRL_A);
		rd(CM_OFS_CTRL_B, CM_RST_CTRL_B);
		bus(1'b1, CM_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
		rd(CM_OFS_STATUS, 32'h0020_0002);
		rd(4'hC, 32'h0000_0000);
		$display("Done: reset and map");
		for (int i = 0; i < 5; i++) begin
			e = {8'h00, mv[i], 6'h00, i[1:0], 1'b0, pc[i], 4'h0};
			bus(1'b1, CM_OFS_CTRL_A, e, 4'hF);
			rd(CM_OFS_CTRL_A, e);
			r = dv[i] * int'(mv[i]);
			rd(CM_OFS_STATUS, {5'h00, r[10:0], 13'h0, r > 120, r >= 24 && r <= 480, 1'b0});
			chk(charge_pump_select === i[1:0], "charge pump");
		end
		$display("Done: divider table");
		repeat (4) begin
			lfsr = nx(lfsr);
			t = lfsr[5:0];
			bus(1'b1, CM_OFS_CTRL_B, {18'h3FFFF, t, 8'hFE}, 4'h2);
			rd(CM_OFS_CTRL_B, 32'h0001_C001 | {18'h0, t, 8'h00});
			chk(vco_coarse_tune === t, "coarse tune");
		end
		$display("Done: coarse tune");
		burst(8'h06, 4'h3, 1'b0);
		chk(n_dac == 6 && n_rr == n_wr, "bypass counts");
		$display("Done: bypass");
		bus(1'b1, CM_OFS_CTRL_A, 32'h0006_0141, 4'hF);
		bus(1'b1, CM_OFS_CTRL_B, 32'h0103_0000, 4'hF);
		mode_byp = 1'b0;
		rd(CM_OFS_STATUS, 32'h0018_0003);
		chk(vco_enable === 1'b1, "loop awake");
		burst(8'h0C, 4'h5, 1'b1);
		chk(n_str == 4, "strobe per N edges");
		chk(n_rr == 4, "read reset by strobe");
		chk(n_dac >= n_cy / 4 - 1 && n_dac <= n_cy / 4 + 1, "multiplied clock");
		chk(n_up >= 1 && n_dn >= 1, "phase detector pulses");
		bus(1'b1, CM_OFS_CTRL_A, 32'h0004_0171, 4'hF);
		burst(8'h03, 4'h7, 1'b0);
		chk(n_str == 1 && n_dac >= n_cy / 8 - 1 && n_dac <= n_cy / 8 + 1, "divide by 8");
		$display("Done: multiplier");
		bus(1'b1, CM_OFS_CTRL_B, 32'h0103_0001, 4'h1);
		repeat (2) @(posedge clk);
		burst(8'h04, 4'h3, 1'b1);
		chk(vco_enable === 1'b0 && n_dac == 0, "sleep");
		chk(n_up + n_dn == 0 && n_rr == n_str, "strobe passed in sleep");
		$display("Done: sleep");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
